// ===== design/flrl_consts.vh
// Constants of the fault latch and reset logic: register offsets, reset values,
// assignment codes, fault codes and timing figures.
// Assumes inclusion by the design file of the block and by the bench.
`ifndef FLRL_CONSTS_VH
`define FLRL_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FLRL_OFS_RESTART_WAIT   8'h00
`define FLRL_OFS_SYNC_FREQ      8'h04
`define FLRL_OFS_RESET_EDGE     8'h08
`define FLRL_OFS_POST_RESET     8'h0C
`define FLRL_OFS_RELAY_FUNC     8'h10
`define FLRL_OFS_ASSIGN_LO      8'h14
`define FLRL_OFS_ASSIGN_HI      8'h18
`define FLRL_OFS_STATUS         8'h1C

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FLRL_RST_RESTART_WAIT   16'h000A
`define FLRL_RST_SYNC_FREQ      16'h0000
`define FLRL_RST_RESET_EDGE     2'h0
`define FLRL_RST_POST_RESET     1'h0
`define FLRL_RST_RELAY_FUNC     8'h0D
`define FLRL_RST_ASSIGN_LO      32'h00000012
`define FLRL_RST_ASSIGN_HI      32'h00000000

// ----------------------------------------------------------------------------
// Input assignment codes, fault codes, relay function code, settings values
// ----------------------------------------------------------------------------
`define FLRL_FN_EXT_FAULT       8'h0C
`define FLRL_FN_START_PROT      8'h0D
`define FLRL_FN_FAULT_RESET     8'h12
`define FLRL_CODE_NONE          8'h00
`define FLRL_CODE_UNDERVOLT     8'h09
`define FLRL_CODE_EXT_FAULT     8'h0C
`define FLRL_CODE_START_PROT    8'h0D
`define FLRL_RELAY_EXT_TRIP     8'h0D
`define FLRL_EDGE_RISE          2'h0
`define FLRL_EDGE_FALL          2'h1
`define FLRL_EDGE_RISE_FAULT    2'h2

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define FLRL_ST_EXT_BIT         0
`define FLRL_ST_SP_BIT          1
`define FLRL_ST_UV_BIT          2
`define FLRL_ST_RELAY_BIT       3
`define FLRL_ST_DRIVE_BIT       4
`define FLRL_ST_TRIP_BIT        5
`define FLRL_ST_CODE_LSB        8
`define FLRL_ST_STATE_LSB       16

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FLRL_CLK_KHZ            40000
`define FLRL_SP_WINDOW_MS       3000
`define FLRL_WAIT_TICK_MS       100

`endif

// ===== design/flrl_top.v
// Fault trip, acknowledge and unattended start protection logic of a motor drive.
// Assumes digital inputs, keypad key, run commands and mains status arrive
// asynchronously, and registers are reached over an AXI4-Lite slave port.
`include "flrl_consts.vh"
`default_nettype none

// Behaviour
// - Active external fault input raises code twelve.
// - External fault stays latched until reset.
// - Reset input, stop key or power-up clears faults.
// - Input codes: 12 fault, 13 protection, 18 reset.
// - External fault trip disables output drive.
// - Run command at reset restarts the motor.
// - Run at supply return blocks start, code thirteen.
// - Stop key, reset or withdrawn run clear protection.
// - Run within three seconds of recovery trips protection.
// - Protection still works after undervoltage reset.
// - Edge setting: rise, fall, rise only when faulted.
// - Post-reset setting: zero start or synchronised start.
// - Synchronisation frequency sets synchronised restart frequency.
// - Programmable restart delay precedes automatic restart.
// - Reset input always active high, not invertible.
// - Reset while running makes the motor coast.
// - Relay setting 13 shows external fault trip.
// - Reset function defaults to digital input one.
module flrl_top #(
	parameter integer SP_WINDOW_CYC = `FLRL_SP_WINDOW_MS * `FLRL_CLK_KHZ,
	parameter integer WAIT_TICK_CYC = `FLRL_WAIT_TICK_MS * `FLRL_CLK_KHZ,
	parameter integer ADDR_W        = 8
) (
	input  wire              aclk,                  // System clock, 40 MHz.
	input  wire              aresetn,               // Synchronous reset, active low.
	input  wire [ADDR_W-1:0] s_axi_awaddr,          // Write address.
	input  wire [2:0]        s_axi_awprot,          // Write protection, unused.
	input  wire              s_axi_awvalid,         // Write address valid.
	output reg               s_axi_awready,         // Write address ready.
	input  wire [31:0]       s_axi_wdata,           // Write data.
	input  wire [3:0]        s_axi_wstrb,           // Write byte strobes.
	input  wire              s_axi_wvalid,          // Write data valid.
	output reg               s_axi_wready,          // Write data ready.
	output reg  [1:0]        s_axi_bresp,           // Write response.
	output reg               s_axi_bvalid,          // Write response valid.
	input  wire              s_axi_bready,          // Write response ready.
	input  wire [ADDR_W-1:0] s_axi_araddr,          // Read address.
	input  wire [2:0]        s_axi_arprot,          // Read protection, unused.
	input  wire              s_axi_arvalid,         // Read address valid.
	output reg               s_axi_arready,         // Read address ready.
	output reg  [31:0]       s_axi_rdata,           // Read data.
	output reg  [1:0]        s_axi_rresp,           // Read response.
	output reg               s_axi_rvalid,          // Read data valid.
	input  wire              s_axi_rready,          // Read data ready.
	input  wire [7:0]        digital_inputs,        // Programmable digital inputs 1 to 8.
	input  wire              forward_run_command,   // Forward run command.
	input  wire              reverse_run_command,   // Reverse run command.
	input  wire              keypad_stop_key,       // Keypad stop/reset key, high pressed.
	input  wire              mains_ok,              // Supply present, low on mains fault.
	output reg               drive_enable,          // Output stage enabled.
	output reg               start_sync,            // Start by speed synchronisation.
	output reg  [15:0]       start_frequency,       // Start frequency for this start.
	output reg               trip,                  // Any latched fault.
	output reg  [7:0]        fault_code,            // Code of the highest fault.
	output reg               signalling_relay_contact // Relay contact drive.
);

	// ------------------------------------------------------------------------
	// Local definitions
	// ------------------------------------------------------------------------
	localparam [1:0] ST_STOP = 2'h0;
	localparam [1:0] ST_RUN  = 2'h1;
	localparam [1:0] ST_WAIT = 2'h2;
	localparam [1:0] RESP_OKAY   = 2'h0;
	localparam [1:0] RESP_SLVERR = 2'h2;
	localparam integer NSYNC = 12;

	// Any input assigned the given function code and currently active.
	function fn_match;
		input [63:0] asg;
		input [7:0]  din;
		input [7:0]  code;
		integer      k;
		begin
			fn_match = 1'b0;
			for (k = 0; k < 8; k = k + 1) begin
				if (din[k] && asg[8*k +: 8] == code)
					fn_match = 1'b1;
			end
		end
	endfunction

	function [31:0] fn_merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      k;
		begin
			fn_merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k])
					fn_merge[8*k +: 8] = data[8*k +: 8];
			end
		end
	endfunction

	// ------------------------------------------------------------------------
	// Registers and nets
	// ------------------------------------------------------------------------
	reg  [NSYNC-1:0]  meta_q;
	reg  [NSYNC-1:0]  sync_q;
	reg               rst_in_prev_q;
	reg               key_prev_q;
	reg               mains_prev_q;
	reg  [15:0]       restart_wait_time_q;
	reg  [15:0]       sync_restart_frequency_q;
	reg  [1:0]        reset_edge_select_q;
	reg               post_reset_start_mode_q;
	reg  [7:0]        relay_function_setting_q;
	reg  [63:0]       input_assignment_q;
	reg               ext_flag_q;
	reg               sp_flag_q;
	reg               uv_flag_q;
	reg  [31:0]       sp_window_q;
	reg  [1:0]        state_q;
	reg  [1:0]        state_d;
	reg               restart_pend_q;
	reg  [31:0]       tick_q;
	reg  [15:0]       wait_ticks_q;
	reg               aw_have_q;
	reg               w_have_q;
	reg  [ADDR_W-1:0] aw_addr_q;
	reg  [31:0]       w_data_q;
	reg  [3:0]        w_strb_q;
	reg               reset_event;

	wire [7:0] din_s    = sync_q[7:0];
	wire       run      = sync_q[8] | sync_q[9];
	wire       key_s    = sync_q[10];
	wire       mains_s  = sync_q[11];
	wire       ext_act  = fn_match(input_assignment_q, din_s, `FLRL_FN_EXT_FAULT);
	wire       usp_en   = fn_match(input_assignment_q, din_s, `FLRL_FN_START_PROT);
	wire       rst_in   = fn_match(input_assignment_q, din_s, `FLRL_FN_FAULT_RESET);
	wire       fault    = ext_flag_q | sp_flag_q | uv_flag_q;
	wire       key_evt  = key_s & ~key_prev_q & fault;
	wire       clr_evt  = reset_event | key_evt;
	wire       win_act  = (sp_window_q != 32'h00000000);
	wire       wr_go    = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire [31:0] status_word;
	wire [31:0] wt_mrg = fn_merge({16'h0000, restart_wait_time_q}, w_data_q, w_strb_q);
	wire [31:0] fq_mrg = fn_merge({16'h0000, sync_restart_frequency_q}, w_data_q, w_strb_q);

	// Reset recognition follows the edge setting; the input is never inverted.
	always @* begin
		case (reset_edge_select_q)
			`FLRL_EDGE_RISE:       reset_event = rst_in & ~rst_in_prev_q;
			`FLRL_EDGE_FALL:       reset_event = ~rst_in & rst_in_prev_q;
			`FLRL_EDGE_RISE_FAULT: reset_event = rst_in & ~rst_in_prev_q & fault;
			default:               reset_event = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q        <= {NSYNC{1'b0}};
			sync_q        <= {NSYNC{1'b0}};
			rst_in_prev_q <= 1'b0;
			key_prev_q    <= 1'b0;
			mains_prev_q  <= 1'b0;
		end else begin
			meta_q        <= {mains_ok, keypad_stop_key, reverse_run_command,
				forward_run_command, digital_inputs};
			sync_q        <= meta_q;
			rst_in_prev_q <= rst_in;
			key_prev_q    <= key_s;
			mains_prev_q  <= mains_s;
		end
	end

	// ------------------------------------------------------------------------
	// Latched fault flags
	// ------------------------------------------------------------------------
	// A setting condition wins over a clear in the same cycle, so an external fault
	// or start protection cause still present cannot be acknowledged away.
	always @(posedge aclk) begin
		if (!aresetn) begin
			ext_flag_q  <= 1'b0;
			sp_flag_q   <= 1'b0;
			uv_flag_q   <= 1'b0;
			sp_window_q <= SP_WINDOW_CYC;
		end else begin
			ext_flag_q <= ext_act | (ext_flag_q & ~clr_evt);
			sp_flag_q  <= (usp_en & run & (win_act | ~mains_s)) |
				(sp_flag_q & ~clr_evt & run);
			uv_flag_q  <= (~mains_s & mains_prev_q) | (uv_flag_q & ~clr_evt);
			// The window restarts on every recovery and is not touched by an
			// acknowledge, so protection stays armed after an undervoltage reset.
			if (!mains_s)
				sp_window_q <= SP_WINDOW_CYC;
			else if (win_act)
				sp_window_q <= sp_window_q - 32'h00000001;
		end
	end

	// ------------------------------------------------------------------------
	// Drive sequencing
	// ------------------------------------------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_STOP: begin
				if (run & ~fault & mains_s & ~win_act)
					state_d = restart_pend_q ? ST_WAIT : ST_RUN;
				else if (run & ~fault & mains_s & ~usp_en)
					state_d = restart_pend_q ? ST_WAIT : ST_RUN;
			end
			ST_RUN: begin
				if (fault | reset_event | ~run | ~mains_s)
					state_d = ST_STOP;
			end
			ST_WAIT: begin
				if (fault | ~run | ~mains_s)
					state_d = ST_STOP;
				else if (wait_ticks_q == 16'h0000)
					state_d = ST_RUN;
			end
			default: state_d = ST_STOP;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q         <= ST_STOP;
			restart_pend_q  <= 1'b0;
			tick_q          <= 32'h00000000;
			wait_ticks_q    <= 16'h0000;
			drive_enable    <= 1'b0;
			start_sync      <= 1'b0;
			start_frequency <= 16'h0000;
		end else begin
			state_q      <= state_d;
			drive_enable <= (state_d == ST_RUN);
			if (fault | (state_q == ST_RUN & reset_event))
				restart_pend_q <= 1'b1;
			else if (state_q != ST_RUN & state_d == ST_RUN)
				restart_pend_q <= 1'b0;
			if (state_q != ST_RUN & state_d == ST_RUN) begin
				start_sync      <= restart_pend_q & post_reset_start_mode_q;
				start_frequency <= (restart_pend_q & post_reset_start_mode_q) ?
					sync_restart_frequency_q : 16'h0000;
			end
			if (state_q != ST_WAIT) begin
				tick_q       <= 32'h00000000;
				wait_ticks_q <= restart_wait_time_q;
			end else if (tick_q == WAIT_TICK_CYC - 1) begin
				tick_q <= 32'h00000000;
				if (wait_ticks_q != 16'h0000)
					wait_ticks_q <= wait_ticks_q - 16'h0001;
			end else begin
				tick_q <= tick_q + 32'h00000001;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Trip indication and relay
	// ------------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			trip                     <= 1'b0;
			fault_code               <= `FLRL_CODE_NONE;
			signalling_relay_contact <= 1'b0;
		end else begin
			trip <= fault;
			if (ext_flag_q)
				fault_code <= `FLRL_CODE_EXT_FAULT;
			else if (sp_flag_q)
				fault_code <= `FLRL_CODE_START_PROT;
			else if (uv_flag_q)
				fault_code <= `FLRL_CODE_UNDERVOLT;
			else
				fault_code <= `FLRL_CODE_NONE;
			if (relay_function_setting_q == `FLRL_RELAY_EXT_TRIP)
				signalling_relay_contact <= ext_flag_q;
			else
				signalling_relay_contact <= fault;
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite write channel and settings
	// ------------------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready            <= 1'b1;
			s_axi_wready             <= 1'b1;
			s_axi_bvalid             <= 1'b0;
			s_axi_bresp              <= RESP_OKAY;
			aw_have_q                <= 1'b0;
			w_have_q                 <= 1'b0;
			aw_addr_q                <= {ADDR_W{1'b0}};
			w_data_q                 <= 32'h00000000;
			w_strb_q                 <= 4'h0;
			restart_wait_time_q      <= `FLRL_RST_RESTART_WAIT;
			sync_restart_frequency_q <= `FLRL_RST_SYNC_FREQ;
			reset_edge_select_q      <= `FLRL_RST_RESET_EDGE;
			post_reset_start_mode_q  <= `FLRL_RST_POST_RESET;
			relay_function_setting_q <= `FLRL_RST_RELAY_FUNC;
			input_assignment_q       <= {`FLRL_RST_ASSIGN_HI, `FLRL_RST_ASSIGN_LO};
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (wr_go) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				case (aw_addr_q)
					`FLRL_OFS_RESTART_WAIT: restart_wait_time_q <= wt_mrg[15:0];
					`FLRL_OFS_SYNC_FREQ: sync_restart_frequency_q <= fq_mrg[15:0];
					`FLRL_OFS_RESET_EDGE: begin
						if (w_strb_q[0])
							reset_edge_select_q <= w_data_q[1:0];
					end
					`FLRL_OFS_POST_RESET: begin
						if (w_strb_q[0])
							post_reset_start_mode_q <= w_data_q[0];
					end
					`FLRL_OFS_RELAY_FUNC: begin
						if (w_strb_q[0])
							relay_function_setting_q <= w_data_q[7:0];
					end
					`FLRL_OFS_ASSIGN_LO: input_assignment_q[31:0] <=
						fn_merge(input_assignment_q[31:0], w_data_q, w_strb_q);
					`FLRL_OFS_ASSIGN_HI: input_assignment_q[63:32] <=
						fn_merge(input_assignment_q[63:32], w_data_q, w_strb_q);
					`FLRL_OFS_STATUS: s_axi_bresp <= RESP_OKAY;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------------
	assign status_word = {14'h0000, state_q, fault_code, 2'h0, trip, drive_enable,
		signalling_relay_contact, uv_flag_q, sp_flag_q, ext_flag_q};

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OKAY;
				case (s_axi_araddr)
					`FLRL_OFS_RESTART_WAIT: s_axi_rdata <= {16'h0000, restart_wait_time_q};
					`FLRL_OFS_SYNC_FREQ:
						s_axi_rdata <= {16'h0000, sync_restart_frequency_q};
					`FLRL_OFS_RESET_EDGE:   s_axi_rdata <= {30'h00000000, reset_edge_select_q};
					`FLRL_OFS_POST_RESET:
						s_axi_rdata <= {31'h00000000, post_reset_start_mode_q};
					`FLRL_OFS_RELAY_FUNC:
						s_axi_rdata <= {24'h000000, relay_function_setting_q};
					`FLRL_OFS_ASSIGN_LO:    s_axi_rdata <= input_assignment_q[31:0];
					`FLRL_OFS_ASSIGN_HI:    s_axi_rdata <= input_assignment_q[63:32];
					`FLRL_OFS_STATUS:       s_axi_rdata <= status_word;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

endmodule // flrl_top

`default_nettype wire

// ===== bench/flrl_partner.sv
// Operator side model: programmable digital inputs and the keypad stop key.
// Assumes the bench calls its tasks just after a rising clock edge.
`default_nettype none
module flrl_partner (
	input  wire logic       aclk,            // System clock.
	output wire logic [7:0] digital_inputs,  // Inputs 1 to 8, high active.
	output wire logic       keypad_stop_key  // Stop key, high pressed.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] lvl_q = 9'h000;

	assign digital_inputs  = lvl_q[7:0];
	assign keypad_stop_key = lvl_q[8];

	task automatic level(input int idx, input logic v);
		lvl_q[idx] <= v;
	endtask

	// A contact closes briefly and opens again; one held for seconds could trip falsely.
	task automatic pulse(input int idx, input int len);
		lvl_q[idx] <= 1'b1;
		repeat (len) @(posedge aclk);
		lvl_q[idx] <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
endmodule // flrl_partner
`default_nettype wire

// ===== bench/flrl_monitor.sv
// Checker of the fault latch and reset logic on the top module's ports.
// Assumes one clock domain with a synchronous active-low reset.
`default_nettype none
module flrl_monitor (
	input wire logic        aclk,                     // Clock.
	input wire logic        aresetn,                  // Reset, active low.
	input wire logic        s_axi_awvalid,            // Write address valid.
	input wire logic        s_axi_awready,            // Write address ready.
	input wire logic        s_axi_wvalid,             // Write data valid.
	input wire logic        s_axi_wready,             // Write data ready.
	input wire logic        s_axi_bvalid,             // Write response valid.
	input wire logic        s_axi_bready,             // Write response ready.
	input wire logic [1:0]  s_axi_bresp,              // Write response.
	input wire logic        s_axi_arvalid,            // Read address valid.
	input wire logic        s_axi_arready,            // Read address ready.
	input wire logic        s_axi_rvalid,             // Read data valid.
	input wire logic        s_axi_rready,             // Read data ready.
	input wire logic [31:0] s_axi_rdata,              // Read data.
	input wire logic        mains_ok,                 // Supply present.
	input wire logic        drive_enable,             // Output stage on.
	input wire logic        start_sync,               // Synchronised start.
	input wire logic [15:0] start_frequency,          // Start frequency.
	input wire logic        trip,                     // Any fault.
	input wire logic [7:0]  fault_code,               // Highest fault.
	input wire logic        signalling_relay_contact  // Relay drive.
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_trip_code: assert property (trip == (fault_code != 8'h00))
		else $error("trip and fault code disagree");
	a_trip_coasts: assert property (trip |-> !drive_enable)
		else $error("drive on while tripped");
	a_relay_trip: assert property (signalling_relay_contact |-> trip)
		else $error("relay set without trip");
	a_zero_start: assert property (!start_sync |-> start_frequency == 16'h0000)
		else $error("nonzero frequency on plain start");
	a_mains_stop: assert property (!mains_ok [*4] |=> !drive_enable)
		else $error("drive on without supply");
	a_reset_clears: assert property (disable iff (1'b0) !aresetn |=> !trip && !drive_enable)
		else $error("outputs not cleared by reset");
	a_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_r_timing: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");

	c_cleared: cover property (trip ##1 !trip);
	c_started: cover property ($rose(drive_enable));
	c_synced: cover property (start_sync && drive_enable);
endmodule // flrl_monitor

bind flrl_top flrl_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mains_ok, .drive_enable, .start_sync,
	.start_frequency, .trip, .fault_code, .signalling_relay_contact);
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench of the fault latch and reset logic.
// Assumes the design, its constants header, the operator model and the bound checker.
`include "flrl_consts.vh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WIN = 200;
	logic        aclk = 1'b0, aresetn = 1'b0, mains_ok = 1'b1;
	logic        forward_run_command = 1'b0, reverse_run_command = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h876BD8CE;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        drive_enable, start_sync, trip, signalling_relay_contact;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] start_frequency;
	logic [7:0]  fault_code;
	wire  [7:0]  digital_inputs;
	wire         keypad_stop_key;
	logic [65:0] exp_q[$];
	logic [65:0] e;
	int          fail_count = 0, tests_run = 0, cyc = 0;

	flrl_top #(.SP_WINDOW_CYC(WIN), .WAIT_TICK_CYC(2)) uut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.digital_inputs, .forward_run_command, .reverse_run_command, .keypad_stop_key, .mains_ok,
		.drive_enable, .start_sync, .start_frequency, .trip, .fault_code, .signalling_relay_contact);
	flrl_partner prt (.aclk, .digital_inputs, .keypad_stop_key);

	initial forever #12.5 aclk = ~aclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({2'h0, 32'h3, 30'h0, r});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		exp_q.push_back({a[5], 1'b0, m, x});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	task automatic st(input logic [31:0] m, input logic [31:0] x);
		rd(`FLRL_OFS_STATUS, m, x);
	endtask

	// Each handshake takes the oldest expectation.
	always @(posedge aclk) begin
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
			e = exp_q.pop_front();
			check((s_axi_rvalid ? s_axi_rdata : {30'h0, s_axi_bresp}) & e[63:32], e[31:0]);
			if (s_axi_rvalid) check(32'(s_axi_rresp), 32'(e[65:64]));
		end
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`FLRL_OFS_RESTART_WAIT, 32'hFFFFFFFF, {16'h0, `FLRL_RST_RESTART_WAIT});
		rd(`FLRL_OFS_RESET_EDGE, 32'hFFFFFFFF, {30'h0, `FLRL_EDGE_RISE});
		rd(`FLRL_OFS_POST_RESET, 32'hFFFFFFFF, 32'h0);
		rd(`FLRL_OFS_ASSIGN_LO, 32'hFFFFFFFF, {24'h0, `FLRL_FN_FAULT_RESET});
		rd(`FLRL_OFS_RELAY_FUNC, 32'hFFFFFFFF, {24'h0, `FLRL_RELAY_EXT_TRIP});
		wr(8'h20, 32'h1, 2'h2);
		rd(8'h20, 32'hFFFFFFFF, 32'h0);
		wr(`FLRL_OFS_STATUS, 32'hFFFFFFFF, 2'h0);
		rnd = xs(rnd);
		wr(`FLRL_OFS_SYNC_FREQ, rnd, 2'h0);
		rd(`FLRL_OFS_SYNC_FREQ, 32'hFFFFFFFF, {16'h0, rnd[15:0]});
		wr(`FLRL_OFS_POST_RESET, 32'h1, 2'h0);
		rd(`FLRL_OFS_POST_RESET, 32'hFFFFFFFF, 32'h1);
		wr(`FLRL_OFS_ASSIGN_LO, {8'h0, `FLRL_FN_START_PROT, `FLRL_FN_EXT_FAULT,
			`FLRL_FN_FAULT_RESET}, 2'h0);
		repeat (WIN) @(posedge aclk);
		forward_run_command <= 1'b1;
		repeat (8) @(posedge aclk);
		st(32'h0003_0010, 32'h0001_0010);
		prt.pulse(1, 3 + int'(rnd[1:0]));
		st(32'h0000_FF3F, 32'h0000_0C29);
		prt.pulse(0, 5);
		st(32'h0003_003F, 32'h0002_0000);
		repeat (24) @(posedge aclk);
		st(32'h0003_0010, 32'h0001_0010);
		check(32'({start_sync, start_frequency}), 32'({1'b1, rnd[15:0]}));
		prt.pulse(0, 3);
		st(32'h0000_0010, 32'h0);
		forward_run_command <= 1'b0;
		for (int m = 0; m < 3; m++) begin
			wr(`FLRL_OFS_RESET_EDGE, 32'(m), 2'h0);
			prt.pulse(1, 3);
			prt.level(0, 1'b1);
			repeat (6) @(posedge aclk);
			st(32'h1, {31'h0, m == 1});
			prt.level(0, 1'b0);
			repeat (6) @(posedge aclk);
			st(32'h1, 32'h0);
		end
		prt.pulse(1, 3);
		prt.pulse(8, 3);
		st(32'h3F, 32'h0);
		prt.level(2, 1'b1);
		reverse_run_command <= 1'b1;
		mains_ok <= 1'b0;
		repeat (6) @(posedge aclk);
		mains_ok <= 1'b1;
		repeat (6) @(posedge aclk);
		st(32'h7, 32'h6);
		reverse_run_command <= 1'b0;
		repeat (6) @(posedge aclk);
		st(32'h7, 32'h4);
		prt.pulse(0, 3);
		st(32'h7, 32'h0);
		forward_run_command <= 1'b1;
		repeat (6) @(posedge aclk);
		st(32'h0000_FF07, 32'h0000_0D02);
		repeat (WIN) @(posedge aclk);
		prt.pulse(8, 3);
		st(32'h7, 32'h0);
		forward_run_command <= 1'b0;
		stop_test();
	end
endmodule // testbench
`default_nettype wire
